/* File: hw/vpd_params.svh */
`ifndef VPD_PARAMS_SVH
`define VPD_PARAMS_SVH

// operation codes understood by the interpreter
`define VPD_OP_TUR      8'h00
`define VPD_OP_READ6    8'h08
`define VPD_OP_WRITE6   8'h0A
`define VPD_OP_INQUIRY  8'h12
`define VPD_OP_SSU      8'h1B
`define VPD_OP_PAMR     8'h1E
`define VPD_OP_READ10   8'h28
`define VPD_OP_WRITE10  8'h2A

// status bytes
`define VPD_STS_GOOD    8'h00
`define VPD_STS_CHECK   8'h02
`define VPD_STS_RESV    8'h18

// sense keys
`define VPD_KEY_NONE    4'h0
`define VPD_KEY_NREADY  4'h2
`define VPD_KEY_ILLEGAL 4'h5

// byte 0 of every page: qualifier bits 7:5, device type bits 4:0
`define VPD_PQUAL       3'h0
`define VPD_PDTYPE      5'h00

// page codes and page geometry
`define VPD_PG_SUPPORT  8'h00
`define VPD_PG_SERIAL   8'h80
`define VPD_HDR_LEN     8'h04
`define VPD_SUP_LEN     8'h02
`define VPD_SN_LEN      8'h10
`define VPD_SN_LAST     8'h13
`define VPD_SN_BITS     128
`define VPD_SPACE       8'h20
`define VPD_RSVD        8'h00

// output buffer shape
`define VPD_FIFO_DEPTH  8
`define VPD_FIFO_WIDTH  9

`endif

/* File: hw/vpd_pkg.sv */
package vpd_pkg;

	// codes idle 0, send 1, status 2, flush 3; flush is send's code with bit 1 set
	typedef enum logic [1:0] {
		st_idle   = 2'h0,
		st_send   = 2'h1,
		st_flush  = 2'h3,
		st_status = 2'h2
	} vpd_state_e;

	// whole state of the interpreter
	typedef struct packed {
		vpd_state_e  st;
		logic [1:0]  sync1;
		logic [1:0]  sync2;
		logic        spun;
		logic        prevent;
		logic        cmd_ready;
		logic [7:0]  page;
		logic [7:0]  idx;
		logic [7:0]  limit;
		logic        sts_valid;
		logic [7:0]  sts_code;
		logic [3:0]  sts_key;
		logic        unit_ready;
		logic        flush_req;
		logic        eject_req;
	} vpd_state_s;

endpackage

/* File: hw/vpd_fifo.sv */
`timescale 1ns/1ps

// small buffer with a registered output stage
module vpd_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	// all storage and pointers in one word
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 count;
		logic                        ovalid;
		logic [WIDTH-1:0]            odata;
	} vpd_fifo_s;

	vpd_fifo_s r;   // registered state
	vpd_fifo_s n;   // next state
	logic      push;
	logic      pop;

	// full stalls the writer; the output stage refills when drained
	always_comb begin
		n         = r;
		in_ready  = (r.count != (AW+1)'(DEPTH));
		push      = in_valid && in_ready;
		pop       = (r.count != '0) && (!r.ovalid || out_ready);
		if (out_ready) begin
			n.ovalid = 1'b0;
		end
		if (pop) begin
			n.odata  = r.mem[r.rptr];
			n.ovalid = 1'b1;
			n.rptr   = r.rptr + 1'b1;
		end
		if (push) begin
			n.mem[r.wptr] = in_data;
			n.wptr        = r.wptr + 1'b1;
		end
		// count moves only when exactly one side acts
		if (push && !pop) begin
			n.count = r.count + 1'b1;
		end else if (pop && !push) begin
			n.count = r.count - 1'b1;
		end
		out_valid = r.ovalid;
		out_data  = r.odata;
	end

	// one register for all of it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule

/* File: hw/vpd_cmd.sv */
`timescale 1ns/1ps
`include "vpd_params.svh"

module vpd_cmd (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	// command descriptor from the bus front end
	input  wire logic         cmd_valid,
	output logic              cmd_ready,
	input  wire logic [7:0]   cmd_opcode,
	input  wire logic         cmd_evpd,
	input  wire logic [7:0]   cmd_page,
	input  wire logic [7:0]   cmd_alloc,
	input  wire logic [31:0]  cmd_lba,
	input  wire logic [15:0]  cmd_blocks,
	input  wire logic         cmd_start,
	input  wire logic         cmd_loej,
	input  wire logic         cmd_prevent,
	input  wire logic [2:0]   cmd_initiator,
	// completion status
	output logic              sts_valid,
	output logic [7:0]        sts_code,
	output logic [3:0]        sts_key,
	// page data stream
	output logic              dout_valid,
	input  wire logic         dout_ready,
	output logic [7:0]        dout_data,
	output logic              dout_last,
	// unit context from same-clock logic
	input  wire logic [31:0]  capacity,
	input  wire logic         resv_active,
	input  wire logic [2:0]   resv_owner,
	input  wire logic [127:0] serial_text,
	input  wire logic         serial_ok,
	// drive mechanics pins
	input  wire logic         medium_present,
	input  wire logic         cache_dirty,
	output logic              unit_ready,
	output logic              removal_prevented,
	output logic              flush_req,
	output logic              eject_req
);

	vpd_pkg::vpd_state_s r;        // registered state
	vpd_pkg::vpd_state_s n;        // next state
	logic                present_s; // synced medium presence
	logic                dirty_s;   // synced cache dirty
	logic                accept;    // command taken this cycle
	logic                fifo_in_ready;
	logic                push;      // page byte written to buffer
	logic [7:0]          cur_byte;  // byte at current index
	logic                cur_last;  // byte closes the transfer
	logic [8:0]          fifo_out;
	logic                resv_clash;

	// byte of a page at a given index
	function automatic logic [7:0] page_byte(input logic [7:0] page, input logic [7:0] idx,
			input logic [127:0] sn, input logic sok);
		logic [7:0] b;
		logic [3:0] k;
		b = `VPD_RSVD;
		k = 4'(`VPD_SN_LAST - idx);
		case (idx)
			8'h00: b = {`VPD_PQUAL, `VPD_PDTYPE};
			8'h01: b = page;
			8'h02: b = `VPD_RSVD;
			// full length even when the allocation cuts the page short
			8'h03: b = (page == `VPD_PG_SERIAL) ? `VPD_SN_LEN : `VPD_SUP_LEN;
			default: begin
				if (page == `VPD_PG_SERIAL) begin
					// first text byte carries the most significant character
					b = sok ? sn[{k, 3'h0} +: 8] : `VPD_SPACE;
				end else if (idx == 8'h05) begin
					b = `VPD_PG_SERIAL;
				end else begin
					b = `VPD_PG_SUPPORT;
				end
			end
		endcase
		return b;
	endfunction

	// full page size in bytes, header included
	function automatic logic [7:0] page_total(input logic [7:0] page);
		return `VPD_HDR_LEN + ((page == `VPD_PG_SERIAL) ? `VPD_SN_LEN : `VPD_SUP_LEN);
	endfunction

	// whether a block range lies inside the medium
	function automatic logic range_ok(input logic [31:0] lba, input logic [15:0] blocks,
			input logic [31:0] cap);
		logic [32:0] last;
		last = {1'b0, lba} + {17'h00000, blocks} - 33'h000000001;
		if (blocks == 16'h0000) begin
			return lba < cap;
		end
		return last < {1'b0, cap};
	endfunction

	// opcodes that touch the medium
	function automatic logic is_medium(input logic [7:0] op);
		return (op == `VPD_OP_READ6) || (op == `VPD_OP_WRITE6) ||
			(op == `VPD_OP_READ10) || (op == `VPD_OP_WRITE10);
	endfunction

	// pin views come only from the second sync stage, never the first
	assign present_s  = r.sync2[1];
	assign dirty_s    = r.sync2[0];
	assign accept     = cmd_valid && r.cmd_ready;
	assign push       = (r.st == vpd_pkg::st_send) && fifo_in_ready;
	assign cur_byte   = page_byte(r.page, r.idx, serial_text, serial_ok);
	assign cur_last   = (r.idx == r.limit - 8'h01);
	assign resv_clash = resv_active && (resv_owner != cmd_initiator);

	// next-state logic for the whole interpreter
	always_comb begin
		n           = r;
		n.sync1     = {medium_present, cache_dirty};
		n.sync2     = r.sync1;
		n.sts_valid = 1'b0;
		n.eject_req = 1'b0;
		// ready only while medium commands can run
		n.unit_ready = present_s && r.spun;
		case (r.st)
			vpd_pkg::st_idle: begin
				if (accept) begin
					n.cmd_ready = 1'b0;
					n.st        = vpd_pkg::st_status;
					n.sts_valid = 1'b1;
					n.sts_code  = `VPD_STS_GOOD;
					n.sts_key   = `VPD_KEY_NONE;
					case (cmd_opcode)
						`VPD_OP_INQUIRY: begin
							if (!cmd_evpd || ((cmd_page != `VPD_PG_SUPPORT) &&
									(cmd_page != `VPD_PG_SERIAL))) begin
								n.sts_code = `VPD_STS_CHECK;
								n.sts_key  = `VPD_KEY_ILLEGAL;
							end else if (cmd_alloc != 8'h00) begin
								// stream the page, status follows the last byte written to the buffer
								n.sts_valid = 1'b0;
								n.st        = vpd_pkg::st_send;
								n.page      = cmd_page;
								n.idx       = 8'h00;
								n.limit     = (cmd_alloc < page_total(cmd_page)) ?
									cmd_alloc : page_total(cmd_page);
							end
						end
						`VPD_OP_TUR: begin
							if (!(present_s && r.spun)) begin
								n.sts_code = `VPD_STS_CHECK;
								n.sts_key  = `VPD_KEY_NREADY;
							end
						end
						`VPD_OP_SSU: begin
							if (cmd_loej && !cmd_start) begin
								if (r.prevent) begin
									n.sts_code = `VPD_STS_CHECK;
									n.sts_key  = `VPD_KEY_ILLEGAL;
								end else begin
									// demount waits for the cache to drain
									n.sts_valid = 1'b0;
									n.st        = vpd_pkg::st_flush;
									n.flush_req = 1'b1;
								end
							end else begin
								n.spun = cmd_start;
							end
						end
						`VPD_OP_PAMR: begin
							n.prevent = cmd_prevent;
						end
						default: begin
							if (!is_medium(cmd_opcode)) begin
								n.sts_code = `VPD_STS_CHECK;
								n.sts_key  = `VPD_KEY_ILLEGAL;
							end else if (!(present_s && r.spun)) begin
								n.sts_code = `VPD_STS_CHECK;
								n.sts_key  = `VPD_KEY_NREADY;
							end else if (resv_clash) begin
								n.sts_code = `VPD_STS_RESV;
							end else if (!range_ok(cmd_lba, cmd_blocks, capacity)) begin
								n.sts_code = `VPD_STS_CHECK;
								n.sts_key  = `VPD_KEY_ILLEGAL;
							end
						end
					endcase
				end
			end
			vpd_pkg::st_send: begin
				// a full buffer simply holds the index
				if (push) begin
					n.idx = r.idx + 8'h01;
					if (cur_last) begin
						n.st        = vpd_pkg::st_status;
						n.sts_valid = 1'b1;
						n.sts_code  = `VPD_STS_GOOD;
						n.sts_key   = `VPD_KEY_NONE;
					end
				end
			end
			vpd_pkg::st_flush: begin
				// eject only once nothing dirty remains
				if (!dirty_s) begin
					n.flush_req = 1'b0;
					n.eject_req = 1'b1;
					n.spun      = 1'b0;
					n.st        = vpd_pkg::st_status;
					n.sts_valid = 1'b1;
					n.sts_code  = `VPD_STS_GOOD;
					n.sts_key   = `VPD_KEY_NONE;
				end
			end
			vpd_pkg::st_status: begin
				// one quiet cycle so the status pulse never overlaps a take
				n.st        = vpd_pkg::st_idle;
				n.cmd_ready = 1'b1;
			end
			default: begin
				n.st        = vpd_pkg::st_idle;
				n.cmd_ready = 1'b1;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			r           <= '0;
			r.cmd_ready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// page bytes go through the buffer so the bus side can stall
	vpd_fifo #(
		.WIDTH (`VPD_FIFO_WIDTH),
		.DEPTH (`VPD_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.in_valid  (r.st == vpd_pkg::st_send),
		.in_ready  (fifo_in_ready),
		.in_data   ({cur_last, cur_byte}),
		.out_valid (dout_valid),
		.out_ready (dout_ready),
		.out_data  (fifo_out)
	);

	assign dout_data         = fifo_out[7:0];
	assign dout_last         = fifo_out[8];
	assign cmd_ready         = r.cmd_ready;
	assign sts_valid         = r.sts_valid;
	assign sts_code          = r.sts_code;
	assign sts_key           = r.sts_key;
	assign unit_ready        = r.unit_ready;
	assign removal_prevented = r.prevent;
	assign flush_req         = r.flush_req;
	assign eject_req         = r.eject_req;

	// checks on the interpreter
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// medium command taken with the unit usable and not reserved by another initiator
	sequence s_medium_go;
		accept && is_medium(cmd_opcode) && present_s && r.spun && !resv_clash;
	endsequence

	// eject request taken
	sequence s_eject_cmd;
		accept && (cmd_opcode == `VPD_OP_SSU) && cmd_loej && !cmd_start;
	endsequence

	page_code_a: assert property (push && r.idx == 8'h01 |-> cur_byte == r.page)
		else $error("page code byte differs from request");
	list_len_a: assert property (push && r.idx == 8'h03 && r.page == `VPD_PG_SUPPORT |-> cur_byte == 8'h02)
		else $error("supported list length wrong");
	list_order_a: assert property (push && r.page == `VPD_PG_SUPPORT && r.idx > 8'h03 |->
			cur_byte == ((r.idx == 8'h04) ? 8'h00 : 8'h80))
		else $error("supported list not ascending from zero");
	serial_len_a: assert property (push && r.idx == 8'h03 && r.page == `VPD_PG_SERIAL |-> cur_byte == 8'h10)
		else $error("serial length byte wrong");
	// the first text byte is the top character, the last the bottom one
	serial_first_a: assert property (push && r.page == `VPD_PG_SERIAL && r.idx == 8'h04 && serial_ok |->
			cur_byte == serial_text[127:120])
		else $error("high serial character not first");
	serial_last_a: assert property (push && r.page == `VPD_PG_SERIAL && r.idx == 8'h13 && serial_ok |->
			cur_byte == serial_text[7:0] && cur_last)
		else $error("low serial character not last");
	serial_blank_a: assert property (push && r.page == `VPD_PG_SERIAL && r.idx > 8'h03 && !serial_ok |->
			cur_byte == 8'h20)
		else $error("missing serial not spaces");
	header_bytes_a: assert property (push && (r.idx == 8'h00 || r.idx == 8'h02) |->
			cur_byte == ((r.idx == 8'h00) ? {`VPD_PQUAL, `VPD_PDTYPE} : 8'h00))
		else $error("byte zero or reserved byte wrong");
	lba_range_a: assert property (s_medium_go ##0 (cmd_lba >= capacity) |=>
			sts_valid && sts_code == 8'h02 && sts_key == 4'h5)
		else $error("out of range access not checked");
	not_ready_a: assert property (accept && is_medium(cmd_opcode) && !(present_s && r.spun) |=>
			sts_valid && sts_code == 8'h02 && sts_key == 4'h2)
		else $error("missing medium not reported");
	ready_follow_a: assert property (##1 unit_ready == $past(present_s && r.spun))
		else $error("ready flag out of step");
	eject_block_a: assert property (s_eject_cmd ##0 r.prevent |=> sts_code == 8'h02 ##1 !eject_req [*2])
		else $error("prevented eject not refused");
	flush_first_a: assert property ($rose(eject_req) |-> !$past(dirty_s) && $past(flush_req))
		else $error("eject before cache flushed");
	resv_clash_a: assert property (accept && is_medium(cmd_opcode) && present_s && r.spun && resv_clash |=>
			sts_valid && sts_code == 8'h18)
		else $error("foreign reservation not refused");

	// demount held off while the cache still reports dirty data
	sequence s_flush_wait;
		flush_req && dirty_s;
	endsequence

	flush_hold_a: assert property (s_flush_wait |=> flush_req && !eject_req)
		else $error("demount before cache drained");
	eject_pulse_a: assert property (eject_req |=> !eject_req && !flush_req)
		else $error("eject request longer than one cycle");
	// status is a single pulse and the next command may follow it at once
	status_pulse_a: assert property (sts_valid |=> !sts_valid && cmd_ready)
		else $error("status pulse or ready return wrong");
	alloc_stop_a: assert property (push |-> r.idx < r.limit && r.idx < page_total(r.page))
		else $error("byte sent past allocation or page end");

endmodule

/* File: verif/vpd_host_model.sv */
`timescale 1ns/1ps

// initiator-side sink for page bytes; prompt, alternating or stalling
module vpd_host_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// 0 prompt, 1 every other cycle, 2 hold off 40 cycles then prompt
	input  wire logic [1:0] mode,
	// page data stream
	input  wire logic       dout_valid,
	input  wire logic [7:0] dout_data,
	input  wire logic       dout_last,
	output logic            dout_ready
);
	logic [8:0] got [$];   // received {last, byte}
	logic       tog_r;     // alternating ready phase
	logic [5:0] stall_r;   // hold-off counter for mode 2

	// phase and hold-off; the stall outlasts the buffer so it must refuse
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tog_r   <= 1'b0;
			stall_r <= 6'h00;
		end else begin
			tog_r   <= ~tog_r;
			stall_r <= (mode != 2'h2) ? 6'h00 : (stall_r == 6'h28) ? stall_r : stall_r + 6'h01;
		end
	end

	assign dout_ready = (mode == 2'h0) | ((mode == 2'h1) & tog_r) | ((mode == 2'h2) & (stall_r == 6'h28));

	// collect every byte accepted on a ready edge
	always @(posedge sys_clk) begin
		if (reset_n && dout_valid && dout_ready) begin
			got.push_back({dout_last, dout_data});
		end
	end
endmodule

/* File: verif/vpd_pages_and_block_access_tb.sv */
`timescale 1ns/1ps
`include "vpd_params.svh"

// self-checking bench for the command interpreter
module vpd_pages_and_block_access_tb;
	localparam logic [31:0]  CAP = 32'h000003E8;                        // blocks on the medium
	localparam logic [127:0] SN  = 128'h4142434445464748494A4B4C4D4E4F50; // serial text
	logic         sys_clk;
	logic         reset_n;
	logic         cmd_valid;
	logic         cmd_ready;
	logic [7:0]   cmd_opcode;
	logic         cmd_evpd;
	logic [7:0]   cmd_page;
	logic [7:0]   cmd_alloc;
	logic [31:0]  cmd_lba;
	logic [15:0]  cmd_blocks;
	logic         cmd_start;
	logic         cmd_loej;
	logic         cmd_prevent;
	logic [2:0]   cmd_initiator;
	logic         sts_valid;
	logic [7:0]   sts_code;
	logic [3:0]   sts_key;
	logic         dout_valid;
	logic         dout_ready;
	logic [7:0]   dout_data;
	logic         dout_last;
	logic         resv_active;
	logic [2:0]   resv_owner;
	logic         serial_ok;
	logic         medium_present;
	logic         cache_dirty;
	logic         unit_ready;
	logic         removal_prevented;
	logic         flush_req;
	logic         eject_req;
	logic [1:0]   host_mode;   // sink pacing
	int           err_count;
	int           checks;
	int           ej_cnt;      // eject pulses seen

	vpd_cmd u_vpd_cmd (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_opcode(cmd_opcode), .cmd_evpd(cmd_evpd), .cmd_page(cmd_page), .cmd_alloc(cmd_alloc),
		.cmd_lba(cmd_lba), .cmd_blocks(cmd_blocks), .cmd_start(cmd_start), .cmd_loej(cmd_loej),
		.cmd_prevent(cmd_prevent), .cmd_initiator(cmd_initiator), .sts_valid(sts_valid),
		.sts_code(sts_code), .sts_key(sts_key), .dout_valid(dout_valid), .dout_ready(dout_ready),
		.dout_data(dout_data), .dout_last(dout_last), .capacity(CAP), .resv_active(resv_active),
		.resv_owner(resv_owner), .serial_text(SN), .serial_ok(serial_ok),
		.medium_present(medium_present), .cache_dirty(cache_dirty), .unit_ready(unit_ready),
		.removal_prevented(removal_prevented), .flush_req(flush_req), .eject_req(eject_req));

	vpd_host_model u_vpd_host_model (.sys_clk(sys_clk), .reset_n(reset_n), .mode(host_mode),
		.dout_valid(dout_valid), .dout_data(dout_data), .dout_last(dout_last), .dout_ready(dout_ready));

	// free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// eject is a one-cycle pulse, so count it on every edge
	always @(posedge sys_clk) begin
		if (eject_req === 1'b1) ej_cnt++;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// a wait that ran out ends the run as a failure
	task automatic hang(input string nm);
		err_count++;
		$display("unexpected timeout waiting for %s", nm);
		wrap_up();
	endtask

	// one command from take to status; bits are {start, loej, prevent}
	task automatic cmd(input logic [7:0] op, input logic [7:0] pg, input logic [7:0] al, input logic [31:0] lba,
			input logic [15:0] blk, input logic [2:0] bits, input logic [7:0] ec, input logic [3:0] ek);
		int i;
		for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge sys_clk);
		if (i == 50) hang("cmd_ready");
		cmd_opcode = op;
		cmd_page = pg;
		cmd_alloc = al;
		cmd_lba = lba;
		cmd_blocks = blk;
		{cmd_start, cmd_loej, cmd_prevent} = bits;
		cmd_valid = 1'b1;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 300 && sts_valid !== 1'b1; i++) @(negedge sys_clk);
		if (i == 300) hang("sts_valid");
		chk("sts_code", sts_code, ec);
		chk("sts_key", sts_key, ek);
	endtask

	// page request; bytes rebuilt from the page layout and compared one by one
	task automatic inq(input logic [7:0] pg, input logic [7:0] al, input logic sok, input logic [1:0] md);
		int n;
		int i;
		logic [7:0] e;
		n = (pg == 8'h00) ? 6 : 20;
		if (al < n) n = al;
		serial_ok = sok;
		host_mode = md;
		u_vpd_host_model.got.delete();
		cmd(`VPD_OP_INQUIRY, pg, al, 32'h0, 16'h0, 3'h0, `VPD_STS_GOOD, `VPD_KEY_NONE);
		for (i = 0; i < 100 && u_vpd_host_model.got.size() < n; i++) @(negedge sys_clk);
		if (i == 100) hang("page bytes");
		repeat (6) @(negedge sys_clk);
		chk("byte_count", u_vpd_host_model.got.size(), n);
		for (i = 0; i < n; i++) begin
			e = (i == 0) ? {`VPD_PQUAL, `VPD_PDTYPE} : (i == 1) ? pg : (i == 3) ? ((pg == 8'h00) ? 8'h02 : 8'h10) :
				(i < 4) ? 8'h00 : (pg == 8'h00) ? ((i == 4) ? 8'h00 : 8'h80) : sok ? SN[127 - 8 * (i - 4) -: 8] : 8'h20;
			chk("page_byte", u_vpd_host_model.got[i][7:0], e);
			chk("last_flag", u_vpd_host_model.got[i][8], i == n - 1);
		end
		host_mode = 2'h0;
		$display("page %h alloc %0d done", pg, al);
	endtask

	// not ready until started, stop drops ready again
	task automatic t_ready;
		cmd(`VPD_OP_TUR, 8'h0, 8'h0, 32'h0, 16'h0, 3'h0, `VPD_STS_CHECK, `VPD_KEY_NREADY);
		cmd(`VPD_OP_READ10, 8'h0, 8'h0, 32'h0, 16'h1, 3'h0, `VPD_STS_CHECK, `VPD_KEY_NREADY);
		cmd(`VPD_OP_SSU, 8'h0, 8'h0, 32'h0, 16'h0, 3'h4, `VPD_STS_GOOD, `VPD_KEY_NONE);
		repeat (4) @(negedge sys_clk);
		chk("unit_ready", unit_ready, 1'b1);
		cmd(`VPD_OP_TUR, 8'h0, 8'h0, 32'h0, 16'h0, 3'h0, `VPD_STS_GOOD, `VPD_KEY_NONE);
		cmd(`VPD_OP_SSU, 8'h0, 8'h0, 32'h0, 16'h0, 3'h0, `VPD_STS_GOOD, `VPD_KEY_NONE);
		repeat (4) @(negedge sys_clk);
		chk("unit_ready", unit_ready, 1'b0);
		cmd(`VPD_OP_WRITE6, 8'h0, 8'h0, 32'h0, 16'h1, 3'h0, `VPD_STS_CHECK, `VPD_KEY_NREADY);
		cmd(`VPD_OP_SSU, 8'h0, 8'h0, 32'h0, 16'h0, 3'h4, `VPD_STS_GOOD, `VPD_KEY_NONE);
		repeat (4) @(negedge sys_clk);
		$display("ready test done");
	endtask

	// address range edges and a foreign reservation
	task automatic t_range;
		cmd(`VPD_OP_READ10, 8'h0, 8'h0, CAP - 1, 16'h1, 3'h0, `VPD_STS_GOOD, `VPD_KEY_NONE);
		cmd(`VPD_OP_WRITE10, 8'h0, 8'h0, CAP - 1, 16'h2, 3'h0, `VPD_STS_CHECK, `VPD_KEY_ILLEGAL);
		cmd(`VPD_OP_READ6, 8'h0, 8'h0, CAP, 16'h0, 3'h0, `VPD_STS_CHECK, `VPD_KEY_ILLEGAL);
		cmd(`VPD_OP_WRITE6, 8'h0, 8'h0, 32'h0, 16'h0, 3'h0, `VPD_STS_GOOD, `VPD_KEY_NONE);
		resv_active = 1'b1;
		resv_owner = 3'h2;
		cmd(`VPD_OP_READ10, 8'h0, 8'h0, 32'h0, 16'h1, 3'h0, `VPD_STS_RESV, `VPD_KEY_NONE);
		cmd_initiator = 3'h2;
		cmd(`VPD_OP_READ10, 8'h0, 8'h0, 32'h0, 16'h1, 3'h0, `VPD_STS_GOOD, `VPD_KEY_NONE);
		resv_active = 1'b0;
		cmd_initiator = 3'h1;
		$display("range test done");
	endtask

	// eject refused while prevented, then flushed before it is let go
	task automatic t_eject;
		cmd(`VPD_OP_PAMR, 8'h0, 8'h0, 32'h0, 16'h0, 3'h1, `VPD_STS_GOOD, `VPD_KEY_NONE);
		chk("removal_prevented", removal_prevented, 1'b1);
		cmd(`VPD_OP_SSU, 8'h0, 8'h0, 32'h0, 16'h0, 3'h2, `VPD_STS_CHECK, `VPD_KEY_ILLEGAL);
		chk("eject_count", ej_cnt, 0);
		cmd(`VPD_OP_PAMR, 8'h0, 8'h0, 32'h0, 16'h0, 3'h0, `VPD_STS_GOOD, `VPD_KEY_NONE);
		cache_dirty = 1'b1;
		fork
			cmd(`VPD_OP_SSU, 8'h0, 8'h0, 32'h0, 16'h0, 3'h2, `VPD_STS_GOOD, `VPD_KEY_NONE);
			begin
				repeat (12) @(negedge sys_clk);
				chk("flush_req", flush_req, 1'b1);
				chk("eject_count", ej_cnt, 0);
				cache_dirty = 1'b0;
			end
		join
		repeat (4) @(negedge sys_clk);
		chk("eject_count", ej_cnt, 1);
		chk("flush_req", flush_req, 1'b0);
		chk("unit_ready", unit_ready, 1'b0);
		$display("eject test done");
	endtask

	// refused requests: unknown page, page bit clear, unknown opcode
	task automatic t_refuse;
		cmd(`VPD_OP_INQUIRY, 8'h81, 8'h10, 32'h0, 16'h0, 3'h0, `VPD_STS_CHECK, `VPD_KEY_ILLEGAL);
		cmd_evpd = 1'b0;
		cmd(`VPD_OP_INQUIRY, 8'h00, 8'h10, 32'h0, 16'h0, 3'h0, `VPD_STS_CHECK, `VPD_KEY_ILLEGAL);
		cmd_evpd = 1'b1;
		cmd(8'h55, 8'h0, 8'h0, 32'h0, 16'h0, 3'h0, `VPD_STS_CHECK, `VPD_KEY_ILLEGAL);
		$display("refuse test done");
	endtask

	// main sequence
	initial begin
		{reset_n, cmd_valid, cmd_opcode, cmd_page, cmd_alloc, cmd_lba, cmd_blocks} = '0;
		{cmd_start, cmd_loej, cmd_prevent, resv_active, resv_owner, cache_dirty, host_mode} = '0;
		{err_count, checks, ej_cnt} = '0;
		cmd_evpd = 1'b1;
		cmd_initiator = 3'h1;
		serial_ok = 1'b1;
		medium_present = 1'b1;
		repeat (8) @(negedge sys_clk);
		reset_n = 1'b1;
		chk("cmd_ready", cmd_ready, 1'b1);
		chk("unit_ready", unit_ready, 1'b0);
		t_ready();
		t_range();
		inq(8'h00, 8'hFF, 1'b1, 2'h1);
		inq(8'h80, 8'h14, 1'b1, 2'h2);
		inq(8'h80, 8'h05, 1'b1, 2'h0);
		inq(8'h80, 8'h14, 1'b0, 2'h0);
		inq(8'h80, 8'h00, 1'b1, 2'h0);
		t_refuse();
		t_eject();
		wrap_up();
	end
endmodule
